// [include/scd_pkg.sv]
// Constants, codes and the decoded configuration layout for the strap decoder
package scd_pkg;

  // Strap vector width and strap positions
  localparam int STRAP_W = 13;
  localparam int POS_ENABLE = 0;
  localparam int POS_SENS_LO = 2;
  localparam int POS_SENS_HI = 3;
  localparam int POS_SER0 = 5;
  localparam int POS_SER1 = 6;
  localparam int POS_USB_PWR = 7;
  localparam int POS_ANT0 = 8;
  localparam int POS_ANT1 = 10;
  localparam int POS_ANT2 = 11;
  localparam int POS_SER2 = 12;

  // Settle time after reset release before straps are latched
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  // Register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CFG_LO = 4'h4;
  localparam logic [3:0] OFS_CFG_HI = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hc;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_RAW_LSB = 16;

  // Sensitivity modes
  localparam logic [1:0] SENS_AUTO = 2'h0;
  localparam logic [1:0] SENS_FAST = 2'h1;
  localparam logic [1:0] SENS_NORMAL = 2'h2;
  localparam logic [1:0] SENS_HIGH = 2'h3;

  // Output protocol codes
  localparam logic [1:0] PROTO_NONE = 2'h0;
  localparam logic [1:0] PROTO_NMEA = 2'h1;
  localparam logic [1:0] PROTO_BIN = 2'h2;

  // Input protocol masks: bit0 RTCM, bit1 NMEA, bit2 binary
  localparam logic [2:0] INP_ALL = 3'h7;
  localparam logic [2:0] INP_NMEA_BIN = 3'h6;

  // Baud codes
  localparam logic [2:0] BAUD_AUTO = 3'h0;
  localparam logic [2:0] BAUD_4K8 = 3'h1;
  localparam logic [2:0] BAUD_9K6 = 3'h2;
  localparam logic [2:0] BAUD_19K2 = 3'h3;
  localparam logic [2:0] BAUD_38K4 = 3'h4;
  localparam logic [2:0] BAUD_57K6 = 3'h5;
  localparam logic [2:0] BAUD_115K2 = 3'h6;

  // Message levels
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [2:0] LVL_LOW = 3'h1;
  localparam logic [2:0] LVL_MED = 3'h2;
  localparam logic [2:0] LVL_HIGH = 3'h3;
  localparam logic [2:0] LVL_DEBUG = 3'h4;
  localparam logic [2:0] LVL_ROMDEF = 3'h5;

  // Information classes: bit0 user, 1 notice, 2 warning, 3 error, 4 debug
  localparam logic [4:0] INFO_NONE = 5'h00;
  localparam logic [4:0] INFO_STD = 5'h0f;
  localparam logic [4:0] INFO_ALL = 5'h1f;

  // Decoded configuration, 35 bits
  typedef struct packed {
    logic ant_rsvd;
    logic ant_alt;
    logic usb_self;
    logic [2:0] proto_en;
    logic [2:0] inp_usb;
    logic [2:0] inp_uart;
    logic [4:0] info;
    logic [2:0] level;
    logic [1:0] usb_proto;
    logic [2:0] p2_baud;
    logic [1:0] p2_proto;
    logic [2:0] p1_baud;
    logic [1:0] p1_proto;
    logic fixed_int;
    logic [1:0] sens;
  } scd_cfg_s;

  localparam int CFG_W = $bits(scd_cfg_s);

  // Built-in defaults used when strap decoding is off
  localparam scd_cfg_s CFG_ROM = '{
    ant_rsvd: 1'b0, ant_alt: 1'b1, usb_self: 1'b1, proto_en: INP_ALL,
    inp_usb: INP_NMEA_BIN, inp_uart: INP_ALL, info: INFO_STD,
    level: LVL_ROMDEF, usb_proto: PROTO_NMEA, p2_baud: BAUD_57K6,
    p2_proto: PROTO_BIN, p1_baud: BAUD_57K6, p1_proto: PROTO_NMEA,
    fixed_int: 1'b1, sens: SENS_NORMAL};

endpackage

// [include/scd_strap_if.sv]
// Carrier for the latched strap vector between capture and decoder
`timescale 1ns/100ps
`default_nettype none
interface scd_strap_if;
  logic [12:0] straps;
  logic valid;
  modport cap (output straps, output valid);
  modport sink (input straps, input valid);
endinterface
`default_nettype wire

// [design/scd_strap_capture.sv]
// One-shot strap sampler: synchronise, settle, latch once per reset
`timescale 1ns/100ps
`default_nettype none
module scd_strap_capture
  import scd_pkg::*;
(
  input wire logic ref_clk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic [STRAP_W-1:0] strap_pins_i, // Raw strap pin levels
  scd_strap_if.cap sif // Latched straps out
);

  typedef enum logic [0:0] {ST_SETTLE, ST_DONE} scd_cap_e;

  logic [STRAP_W-1:0] sync1_r;
  logic [STRAP_W-1:0] sync2_r;
  logic [CNT_W-1:0] cnt_r;
  scd_cap_e state_r;

  // Two-stage synchroniser; pins are asynchronous to the clock
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= strap_pins_i;
      sync2_r <= sync1_r;
    end
  end

  // Wait out the settle time, then latch exactly once
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ST_SETTLE;
      cnt_r <= '0;
      sif.straps <= '0;
      sif.valid <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_SETTLE:
        begin
          if (cnt_r == CNT_W'(SETTLE_CYC))
          begin
            sif.straps <= sync2_r;
            sif.valid <= 1'b1;
            state_r <= ST_DONE;
          end
          else
          begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        ST_DONE:
        begin
          // Held until the next reset so later pin activity is ignored
          state_r <= ST_DONE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [design/scd_config_top.sv]
// Strap pin configuration decoder with an Avalon-MM register slave
//
// Functional notes
// - Start-up configuration comes from strap levels
// - Enable strap low selects built-in defaults
// - Enable high decodes straps 2,3,5-8,10-12
// - Open straps decode at their pull level
// - Positions 1, 4, 9 never decoded
// - Sensitivity pair selects auto/fast/normal/high
// - Fixed integration except auto adapts
// - Sensitivity affects acquisition only, not tracking
// - Protocol enable first, then messages per protocol
// - All protocols on, one output protocol/port
// - Serial bit2 low table: binary primary
// - Serial bit2 high table: NMEA primary, debug (code: debug entry 7 has binary primary at 115.2, NMEA secondary)
// - Info classes std, none in auto, all debug
// - USB strap 0 bus-powered 100mA, 1 self
// - Antenna code 011 selects alternate pin
// - Defaults: 57.6 both, NMEA, binary, USB NMEA
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module scd_config_top
  import scd_pkg::*;
(
  input wire logic ref_clk_i, // System clock, 10 MHz
  input wire logic nrst_i, // Async reset, active low
  input wire logic [STRAP_W-1:0] strap_pins_i, // Strap pins, bit n = position n
  input wire logic [3:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall, low for one answer cycle
  output logic cfg_valid_o, // Straps latched and decoded
  output logic cfg_ready_o, // Configuration released to firmware
  output logic [1:0] sens_mode_o, // Acquisition sensitivity mode
  output logic acq_fixed_int_o, // Fixed acquisition integration time
  output logic [1:0] p1_proto_o, // Primary port output protocol
  output logic [2:0] p1_baud_o, // Primary port baud code
  output logic [1:0] p2_proto_o, // Secondary port output protocol
  output logic [2:0] p2_baud_o, // Secondary port baud code
  output logic [1:0] usb_proto_o, // USB port output protocol
  output logic [2:0] msg_level_o, // Output message level
  output logic [4:0] info_mask_o, // Information classes emitted
  output logic [2:0] inp_uart_o, // Input protocols accepted on serial
  output logic [2:0] inp_usb_o, // Input protocols accepted on USB
  output logic [2:0] proto_en_o, // Protocols enabled at first stage
  output logic usb_self_pwr_o, // USB reports self-powered
  output logic ant_alt_sel_o, // Antenna detect on alternate pin
  output logic ant_rsvd_o // Reserved antenna code strapped
);

  scd_strap_if sif ();

  logic [31:0] ctrl_r;
  scd_cfg_s cfg_r;
  logic cfg_valid_r;
  logic cfg_ready_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic req;
  logic [31:0] rd_mux;

  // Sampler keeps the strap vector frozen after its one capture
  scd_strap_capture u_cap (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .strap_pins_i(strap_pins_i),
    .sif(sif)
  );

  // Serial table lookup; both halves share the same output fields
  function automatic scd_cfg_s dec_serial(input scd_cfg_s c, input logic [2:0] s);
    scd_cfg_s r;
    r = c;
    r.inp_uart = INP_ALL;
    r.inp_usb = INP_ALL;
    r.proto_en = INP_ALL;
    r.info = INFO_STD;
    unique case (s)
      3'h0:
      begin
        r.p1_proto = PROTO_BIN;
        r.p1_baud = BAUD_57K6;
        r.p2_proto = PROTO_NMEA;
        r.p2_baud = BAUD_19K2;
        r.level = LVL_HIGH;
      end
      3'h1:
      begin
        r.p1_proto = PROTO_BIN;
        r.p1_baud = BAUD_38K4;
        r.p2_proto = PROTO_NMEA;
        r.p2_baud = BAUD_9K6;
        r.level = LVL_MED;
      end
      3'h2:
      begin
        r.p1_proto = PROTO_BIN;
        r.p1_baud = BAUD_19K2;
        r.p2_proto = PROTO_NMEA;
        r.p2_baud = BAUD_4K8;
        r.level = LVL_LOW;
      end
      3'h3:
      begin
        // Auto baud: nothing sent until software enables messages
        r.p1_proto = PROTO_NONE;
        r.p1_baud = BAUD_AUTO;
        r.p2_proto = PROTO_NONE;
        r.p2_baud = BAUD_AUTO;
        r.level = LVL_OFF;
        r.info = INFO_NONE;
      end
      3'h4:
      begin
        r.p1_proto = PROTO_NMEA;
        r.p1_baud = BAUD_19K2;
        r.p2_proto = PROTO_BIN;
        r.p2_baud = BAUD_57K6;
        r.level = LVL_HIGH;
      end
      3'h5:
      begin
        r.p1_proto = PROTO_NMEA;
        r.p1_baud = BAUD_4K8;
        r.p2_proto = PROTO_BIN;
        r.p2_baud = BAUD_19K2;
        r.level = LVL_LOW;
      end
      3'h6:
      begin
        r.p1_proto = PROTO_NMEA;
        r.p1_baud = BAUD_9K6;
        r.p2_proto = PROTO_BIN;
        r.p2_baud = BAUD_38K4;
        r.level = LVL_MED;
      end
      3'h7:
      begin
        r.p1_proto = PROTO_BIN;
        r.p1_baud = BAUD_115K2;
        r.p2_proto = PROTO_NMEA;
        r.p2_baud = BAUD_19K2;
        r.level = LVL_DEBUG;
        r.info = INFO_ALL;
      end
    endcase
    // USB follows the primary port's output protocol
    r.usb_proto = r.p1_proto;
    return r;
  endfunction

  // Full strap decode; unused positions are never looked at
  function automatic scd_cfg_s dec_straps(input logic [STRAP_W-1:0] st);
    scd_cfg_s r;
    logic [2:0] ant;
    r = CFG_ROM;
    ant = {st[POS_ANT2], st[POS_ANT1], st[POS_ANT0]};
    if (st[POS_ENABLE])
    begin
      // Positions 1, 4 and 9 serve other pins and are skipped
      r.sens = {st[POS_SENS_HI], st[POS_SENS_LO]};
      // Only auto adapts; this output feeds acquisition, never tracking
      r.fixed_int = (r.sens != SENS_AUTO);
      r = dec_serial(r, {st[POS_SER2], st[POS_SER1], st[POS_SER0]});
      r.usb_self = st[POS_USB_PWR];
      r.ant_alt = (ant == 3'h3) || (ant == 3'h2) || (ant == 3'h4)
                  || (ant == 3'h5);
      r.ant_rsvd = (ant == 3'h2) || (ant == 3'h4) || (ant == 3'h5);
    end
    return r;
  endfunction

  // Configuration register: defaults until capture, then the decode.
  // Pins left open already arrive at their pull level, so no fill-in here.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_r <= CFG_ROM;
      cfg_valid_r <= 1'b0;
    end
    else if (sif.valid && !cfg_valid_r)
    begin
      cfg_r <= dec_straps(sif.straps);
      cfg_valid_r <= 1'b1;
    end
  end

  // Release to firmware once decoded, unless software holds it back
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_ready_r <= 1'b0;
    end
    else
    begin
      cfg_ready_r <= cfg_valid_r && !ctrl_r[CTRL_HOLD_BIT];
    end
  end

  // Avalon request seen only while waitrequest is high
  assign req = (avs_read_i || avs_write_i) && wait_r;

  // Read mux; unmapped or misaligned addresses read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      OFS_STATUS:
      begin
        rd_mux[0] = cfg_valid_r;
        rd_mux[1] = sif.straps[POS_ENABLE];
        rd_mux[2] = cfg_ready_r;
        rd_mux[3] = cfg_r.ant_rsvd;
        rd_mux[STAT_RAW_LSB +: STRAP_W] = sif.straps;
      end
      OFS_CFG_LO: rd_mux = cfg_r[31:0];
      OFS_CFG_HI: rd_mux[CFG_W-33:0] = cfg_r[CFG_W-1:32];
      OFS_CTRL: rd_mux = ctrl_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access: answer comes on the second cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r <= !req;
      if (req && avs_read_i)
      begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Control register; only byte lane 0 holds a live bit.
  // The write lands on the answer edge, where the master sees waitrequest low.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_r <= CTRL_RST;
    end
    else if (avs_write_i && !wait_r && avs_address_i == OFS_CTRL && avs_byteenable_i[0])
    begin
      ctrl_r[CTRL_HOLD_BIT] <= avs_writedata_i[CTRL_HOLD_BIT];
    end
  end

  // Outputs straight from flops
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign cfg_valid_o = cfg_valid_r;
  assign cfg_ready_o = cfg_ready_r;
  assign sens_mode_o = cfg_r.sens;
  assign acq_fixed_int_o = cfg_r.fixed_int;
  assign p1_proto_o = cfg_r.p1_proto;
  assign p1_baud_o = cfg_r.p1_baud;
  assign p2_proto_o = cfg_r.p2_proto;
  assign p2_baud_o = cfg_r.p2_baud;
  assign usb_proto_o = cfg_r.usb_proto;
  assign msg_level_o = cfg_r.level;
  assign info_mask_o = cfg_r.info;
  assign inp_uart_o = cfg_r.inp_uart;
  assign inp_usb_o = cfg_r.inp_usb;
  assign proto_en_o = cfg_r.proto_en;
  assign usb_self_pwr_o = cfg_r.usb_self;
  assign ant_alt_sel_o = cfg_r.ant_alt;
  assign ant_rsvd_o = cfg_r.ant_rsvd;

endmodule
`default_nettype wire

// [tb/scd_strap_board.sv]
// Board strap wiring model: fitted straps drive a level, open ones sit at the pull
`timescale 1ns/100ps
`default_nettype none
module scd_strap_board
  import scd_pkg::*;
#(
  parameter logic [STRAP_W-1:0] PULL_LVL = 13'h1dce // Pull level per strap, enable pulled low
)
(
  input wire logic [STRAP_W-1:0] fit_i, // Resistor fitted on this strap
  input wire logic [STRAP_W-1:0] lvl_i, // Level of a fitted strap
  output logic [STRAP_W-1:0] pins_o // Level seen at the pins
);
  // Board wiring never floats: an open strap always reads its pull
  assign pins_o = (fit_i & lvl_i) | (~fit_i & PULL_LVL);
endmodule
`default_nettype wire

// [tb/scd_config_chk.sv]
// Port-level checks for the strap decoder, bound to its top
`timescale 1ns/100ps
`default_nettype none
module scd_config_chk
  import scd_pkg::*;
(
  input wire logic ref_clk_i, // Clock
  input wire logic nrst_i, // Reset, active low
  input wire logic [STRAP_W-1:0] strap_pins_i, // Strap pins
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic avs_waitrequest_o, // Stall
  input wire logic cfg_valid_o, // Latched
  input wire logic cfg_ready_o, // Released to firmware
  input wire logic [1:0] sens_mode_o, // Sensitivity
  input wire logic acq_fixed_int_o, // Fixed integration
  input wire logic [2:0] p1_baud_o, // Primary baud
  input wire logic [2:0] msg_level_o, // Message level
  input wire logic [4:0] info_mask_o, // Info classes
  input wire logic usb_self_pwr_o, // USB power
  input wire logic ant_alt_sel_o // Antenna pin
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Capture timing: settle window first, then a bounded wait for the latch
  sequence s_settle;
    !cfg_valid_o [*8];
  endsequence
  sequence s_valid_up;
    ##[1:8] cfg_valid_o;
  endsequence

  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered next cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer cycle longer than one");
  a_valid_time: assert property ($rose(nrst_i) |-> s_settle ##0 s_valid_up)
    else $error("straps not latched in the expected window");
  a_valid_stays: assert property (cfg_valid_o |=> cfg_valid_o)
    else $error("valid dropped before reset");
  a_ready_valid: assert property (cfg_ready_o |-> cfg_valid_o)
    else $error("configuration released before decode");
  a_cfg_hold: assert property (cfg_valid_o && $past(cfg_valid_o) |->
    $stable({sens_mode_o, p1_baud_o, msg_level_o, info_mask_o, ant_alt_sel_o}))
    else $error("configuration changed after latch");
  a_rom_default: assert property ($rose(cfg_valid_o) && !strap_pins_i[POS_ENABLE] |->
    sens_mode_o == SENS_NORMAL && p1_baud_o == BAUD_57K6 && ant_alt_sel_o && usb_self_pwr_o)
    else $error("defaults not applied with enable low");
  a_sens_map: assert property ($rose(cfg_valid_o) && strap_pins_i[POS_ENABLE] |->
    sens_mode_o == strap_pins_i[POS_SENS_HI:POS_SENS_LO]
    && acq_fixed_int_o == (sens_mode_o != SENS_AUTO))
    else $error("sensitivity decode wrong");
  a_usb_power: assert property ($rose(cfg_valid_o) && strap_pins_i[POS_ENABLE] |->
    usb_self_pwr_o == strap_pins_i[POS_USB_PWR])
    else $error("usb power decode wrong");
  a_info_level: assert property (cfg_valid_o |-> (msg_level_o == LVL_OFF) == (info_mask_o == INFO_NONE)
    && (msg_level_o == LVL_DEBUG) == (info_mask_o == INFO_ALL))
    else $error("info classes disagree with level");
endmodule
bind scd_config_top scd_config_chk u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .strap_pins_i(strap_pins_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .cfg_valid_o(cfg_valid_o), .cfg_ready_o(cfg_ready_o),
  .sens_mode_o(sens_mode_o),
  .acq_fixed_int_o(acq_fixed_int_o), .p1_baud_o(p1_baud_o), .msg_level_o(msg_level_o),
  .info_mask_o(info_mask_o), .usb_self_pwr_o(usb_self_pwr_o), .ant_alt_sel_o(ant_alt_sel_o));
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the strap decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import scd_pkg::*;
;
  localparam logic [12:0] PULL = 13'h1dce;
  logic ref_clk_i, nrst_i, avs_read_i, avs_write_i, seen, cfg_valid_o, cfg_ready_o;
  logic [12:0] fit, lvl, pins, last_p;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rnd;
  logic avs_waitrequest_o, acq_fixed_int_o, usb_self_pwr_o, ant_alt_sel_o, ant_rsvd_o;
  logic [1:0] sens_mode_o, p1_proto_o, p2_proto_o, usb_proto_o;
  logic [2:0] p1_baud_o, p2_baud_o, msg_level_o, inp_uart_o, inp_usb_o, proto_en_o;
  logic [4:0] info_mask_o;
  logic [CFG_W-1:0] cfg_q[$], rd_q[$], last_cfg, obs;
  int err_count, n_tests, cyc;

  scd_strap_board board (.fit_i(fit), .lvl_i(lvl), .pins_o(pins));
  scd_config_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .strap_pins_i(pins),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cfg_valid_o(cfg_valid_o), .cfg_ready_o(cfg_ready_o), .sens_mode_o(sens_mode_o),
    .acq_fixed_int_o(acq_fixed_int_o), .p1_proto_o(p1_proto_o), .p1_baud_o(p1_baud_o),
    .p2_proto_o(p2_proto_o), .p2_baud_o(p2_baud_o), .usb_proto_o(usb_proto_o),
    .msg_level_o(msg_level_o), .info_mask_o(info_mask_o), .inp_uart_o(inp_uart_o),
    .inp_usb_o(inp_usb_o), .proto_en_o(proto_en_o), .usb_self_pwr_o(usb_self_pwr_o),
    .ant_alt_sel_o(ant_alt_sel_o), .ant_rsvd_o(ant_rsvd_o));

  // Observed configuration in the packed layout
  assign obs = {ant_rsvd_o, ant_alt_sel_o, usb_self_pwr_o, proto_en_o, inp_usb_o, inp_uart_o,
    info_mask_o, msg_level_o, usb_proto_o, p2_baud_o, p2_proto_o, p1_baud_o, p1_proto_o,
    acq_fixed_int_o, sens_mode_o};

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Expected decode, worked out independently of the design
  function automatic scd_cfg_s exp_cfg(input logic [12:0] s);
    scd_cfg_s c;
    logic [12:0] t;
    logic [2:0] a;
    c = '{1'b0, 1'b1, 1'b1, INP_ALL, INP_NMEA_BIN, INP_ALL, INFO_STD, LVL_ROMDEF, PROTO_NMEA,
      BAUD_57K6, PROTO_BIN, BAUD_57K6, PROTO_NMEA, 1'b1, SENS_NORMAL};
    if (!s[POS_ENABLE])
      return c;
    c.sens = {s[POS_SENS_HI], s[POS_SENS_LO]};
    c.fixed_int = (c.sens != SENS_AUTO);
    c.inp_usb = INP_ALL;
    case ({s[POS_SER2], s[POS_SER1], s[POS_SER0]})
      3'h0: t = {PROTO_BIN, BAUD_57K6, PROTO_NMEA, BAUD_19K2, LVL_HIGH};
      3'h1: t = {PROTO_BIN, BAUD_38K4, PROTO_NMEA, BAUD_9K6, LVL_MED};
      3'h2: t = {PROTO_BIN, BAUD_19K2, PROTO_NMEA, BAUD_4K8, LVL_LOW};
      3'h3: t = {PROTO_NONE, BAUD_AUTO, PROTO_NONE, BAUD_AUTO, LVL_OFF};
      3'h4: t = {PROTO_NMEA, BAUD_19K2, PROTO_BIN, BAUD_57K6, LVL_HIGH};
      3'h5: t = {PROTO_NMEA, BAUD_4K8, PROTO_BIN, BAUD_19K2, LVL_LOW};
      3'h6: t = {PROTO_NMEA, BAUD_9K6, PROTO_BIN, BAUD_38K4, LVL_MED};
      default: t = {PROTO_BIN, BAUD_115K2, PROTO_NMEA, BAUD_19K2, LVL_DEBUG};
    endcase
    {c.p1_proto, c.p1_baud, c.p2_proto, c.p2_baud, c.level} = t;
    c.usb_proto = c.p1_proto;
    c.info = (t[2:0] == LVL_OFF) ? INFO_NONE : (t[2:0] == LVL_DEBUG) ? INFO_ALL : INFO_STD;
    c.usb_self = s[POS_USB_PWR];
    a = {s[POS_ANT2], s[POS_ANT1], s[POS_ANT0]};
    c.ant_alt = (a inside {3'h2, 3'h3, 3'h4, 3'h5});
    c.ant_rsvd = (a inside {3'h2, 3'h4, 3'h5});
    return c;
  endfunction

  task automatic chk(input string nm, input logic [CFG_W-1:0] e, input logic [CFG_W-1:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus transfer, held until waitrequest is seen low; reads leave a note
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
    input logic [CFG_W-1:0] ex);
    if (!wr)
      rd_q.push_back(ex);
    avs_address_i <= adr;
    avs_writedata_i <= wd;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge ref_clk_i);
    // Only the hang guard ends a wait that never sees an answer
    while (avs_waitrequest_o !== 1'b0)
    begin
      @(posedge ref_clk_i);
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Reset with a strap setting, check decode, registers and that later pin changes are ignored
  task automatic run_case(input logic [12:0] f, input logic [12:0] l);
    fit <= f;
    lvl <= l;
    nrst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    last_p = (f & l) | (~f & PULL);
    last_cfg = exp_cfg(last_p);
    cfg_q.push_back(last_cfg);
    nrst_i <= 1'b1;
    while (cfg_valid_o !== 1'b1)
    begin
      @(posedge ref_clk_i);
    end
    repeat (2) @(posedge ref_clk_i);
    bus(1'b0, OFS_CTRL, 32'h0, {3'h0, CTRL_RST});
    bus(1'b0, OFS_CFG_HI, 32'h0, {32'h0, last_cfg[34:32]});
    bus(1'b0, OFS_STATUS, 32'h0, {6'h0, last_p, 12'h0, last_cfg[34], 1'b1, last_p[0], 1'b1});
    fit <= 13'h1fff;
    lvl <= ~last_p;
    repeat (3) @(posedge ref_clk_i);
    bus(1'b0, OFS_CFG_LO, 32'h0, {3'h0, last_cfg[31:0]});
    $display("test done straps %h", last_p);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // Result watcher: oldest note against what the outputs show
  always @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      seen = 1'b0;
    else if (cfg_valid_o === 1'b1 && !seen)
    begin
      seen = 1'b1;
      chk("config", cfg_q.pop_front(), obs);
    end
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
      chk("readdata", rd_q.pop_front(), {3'h0, avs_readdata_o});
  end

  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    logic [12:0] s;
    nrst_i = 1'b0;
    fit = 13'h0;
    lvl = 13'h0;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hf;
    seen = 1'b0;
    {err_count, n_tests, cyc} = '0;
    rnd = 32'h5bb9e75a;
    repeat (20) @(posedge ref_clk_i);
    run_case(13'h0, 13'h0);
    avs_byteenable_i <= 4'he;
    bus(1'b1, OFS_CTRL, 32'h1, '0);
    bus(1'b0, OFS_CTRL, 32'h0, '0);
    avs_byteenable_i <= 4'h1;
    bus(1'b1, OFS_CTRL, 32'h1, '0);
    bus(1'b0, OFS_CTRL, 32'h0, {3'h0, 32'h1});
    bus(1'b0, OFS_STATUS, 32'h0, {6'h0, last_p, 12'h0, 4'h1});
    rnd = lfsr(rnd);
    bus(1'b1, OFS_CFG_LO, rnd, '0);
    bus(1'b0, OFS_CFG_LO, 32'h0, {3'h0, last_cfg[31:0]});
    bus(1'b0, 4'h6, 32'h0, '0);
    run_case(13'h1, 13'h1);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      s = rnd[12:0];
      s[POS_ENABLE] = 1'b1;
      {s[POS_SER2], s[POS_SER1], s[POS_SER0]} = i[2:0];
      {s[POS_ANT2], s[POS_ANT1], s[POS_ANT0]} = 3'h7 - i[2:0];
      {s[POS_SENS_HI], s[POS_SENS_LO]} = i[1:0];
      run_case(13'h1fff, s);
    end
    rnd = lfsr(rnd);
    run_case(13'h1fff, rnd[12:0] & 13'h1ffe);
    chk("pending", '0, CFG_W'(cfg_q.size() + rd_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
